// ### src/flash_id_pkg.sv
package flash_id_pkg;

  // Address and data widths of the flash pin interface
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;

  // Code select on the two lowest address pins
  localparam logic [1:0] SEL_MAKER   = 2'h0;
  localparam logic [1:0] SEL_DEVICE  = 2'h1;
  localparam logic [1:0] SEL_PROTECT = 2'h2;
  localparam logic [1:0] SEL_CONT    = 2'h3;

  // Pin positions inside the address bus
  localparam int ADDR_BIT_HV   = 9;
  localparam int ADDR_BIT_A6   = 6;
  localparam int SECT_LSB      = 12;
  localparam int SECT_W        = 9;
  localparam int SECT_DC_W     = 3;

  // Sector protect answers
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [7:0] PROT_NO  = 8'h00;

  // Topmost sector bounds, byte and word view
  localparam logic [21:0] TOP_SECT_BYTE_LO = 22'h3f0000;
  localparam logic [20:0] TOP_SECT_WORD_LO = 21'h1f8000;

  // Bus timing
  localparam int T_SETUP_NS   = 20;
  localparam int T_ACCESS_NS  = 70;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETUP_CYC  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] CNT_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_HV,
    MODE_CMD
  } entry_mode_t;

endpackage

// ### src/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // Pin side and synchronised side
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // Value changes only once stages two and three agree
  always_comb begin
    out_next = out_reg;
    if (s2_reg == s3_reg) begin
      out_next = s3_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end else begin
      s1_reg  <= pin_i;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_o = out_reg;
endmodule // pin_sync
`default_nettype wire

// ### src/flash_id_host.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Host holds the high-voltage request on pin nine for the whole query.
// - A6 low; A1/A0 pick maker, device, continuation or protect status.
// - Protect query places sector on top bits; 01h protected, 00h not.
// - Maker and device queries carry bank address; continuation ignores it.
// - Read with chip and output enable low, write enable high, after setup.
module flash_id_host
  import flash_id_pkg::*;
#(
  parameter int BANK_BITS = 3
) (
  // Clock and reset
  input  wire logic                             sys_clk_i,
  input  wire logic                             rst_n_i,
  // User request
  input  wire logic                             req_valid_i,
  output logic                                  req_ready_o,
  input  wire logic [1:0]                       req_sel_i,
  input  wire logic [flash_id_pkg::SECT_W-1:0]  req_sector_i,
  input  wire logic [BANK_BITS-1:0]             req_bank_i,
  input  wire logic                             req_byte_mode_i,
  // User answer
  output logic                                  rsp_valid_o,
  output logic [7:0]                            rsp_code_o,
  output logic                                  rsp_protected_o,
  // Flash pins
  output logic [flash_id_pkg::ADDR_W-1:0]       flash_addr_o,
  output logic                                  flash_addr_low_o,
  output logic                                  flash_ce_n_o,
  output logic                                  flash_oe_n_o,
  output logic                                  flash_we_n_o,
  output logic                                  flash_byte_n_o,
  output logic                                  elevated_query_voltage_o,
  input  wire logic [flash_id_pkg::DATA_W-1:0]  flash_data_i
);
  import flash_id_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_READ,
    ST_DONE
  } state_t;

  logic                rst_s1_reg;
  logic                rst_s2_reg;
  logic                rst_n;
  logic [DATA_W-1:0]   data_sync;

  state_t              state_reg;
  state_t              state_next;
  logic [7:0]          cnt_reg;
  logic [7:0]          cnt_next;
  logic [ADDR_W-1:0]   addr_reg;
  logic [ADDR_W-1:0]   addr_next;
  logic [1:0]          sel_reg;
  logic [1:0]          sel_next;
  logic                byte_reg;
  logic                byte_next;
  logic                hv_reg;
  logic                hv_next;
  logic                rd_reg;
  logic                rd_next;
  logic                valid_reg;
  logic                valid_next;
  logic [7:0]          code_reg;
  logic [7:0]          code_next;
  logic                prot_reg;
  logic                prot_next;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  pin_sync #(
    .W (DATA_W)
  ) u_data_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n),
    .pin_i     (flash_data_i),
    .sync_o    (data_sync)
  );

  // Address for the query: code select, A6 low, sector or bank on top bits
  function automatic logic [ADDR_W-1:0] query_addr(
    input logic [1:0]             sel,
    input logic [SECT_W-1:0]      sect,
    input logic [BANK_BITS-1:0]   bank
  );
    logic [ADDR_W-1:0] a;
    a = '0;
    a[1:0] = sel;
    a[ADDR_BIT_A6] = 1'b0;
    if (sel == SEL_PROTECT) begin
      a[ADDR_W-1:SECT_LSB] = sect;
      a[SECT_LSB+SECT_DC_W-1:SECT_LSB] = '0;
    end else if (sel != SEL_CONT) begin
      a[ADDR_W-1 -: BANK_BITS] = bank;
    end
    return a;
  endfunction

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    addr_next  = addr_reg;
    sel_next   = sel_reg;
    byte_next  = byte_reg;
    hv_next    = hv_reg;
    rd_next    = rd_reg;
    valid_next = 1'b0;
    code_next  = code_reg;
    prot_next  = prot_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (req_valid_i) begin
          addr_next  = query_addr(req_sel_i, req_sector_i, req_bank_i);
          sel_next   = req_sel_i;
          byte_next  = req_byte_mode_i;
          hv_next    = 1'b1;
          cnt_next   = CNT_RESET;
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == 8'(SETUP_CYC - 1)) begin
          rd_next    = 1'b1;
          cnt_next   = CNT_RESET;
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        cnt_next = cnt_reg + 8'h01;
        // Access time plus the input synchroniser depth
        if (cnt_reg == 8'(ACCESS_CYC + 3)) begin
          code_next  = data_sync[7:0];
          prot_next  = (sel_reg == SEL_PROTECT) &&
                       (data_sync[7:0] == PROT_YES);
          rd_next    = 1'b0;
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        hv_next    = 1'b0;
        valid_next = 1'b1;
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= CNT_RESET;
      addr_reg  <= '0;
      sel_reg   <= SEL_MAKER;
      byte_reg  <= 1'b0;
      hv_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      valid_reg <= 1'b0;
      code_reg  <= PROT_NO;
      prot_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      addr_reg  <= addr_next;
      sel_reg   <= sel_next;
      byte_reg  <= byte_next;
      hv_reg    <= hv_next;
      rd_reg    <= rd_next;
      valid_reg <= valid_next;
      code_reg  <= code_next;
      prot_reg  <= prot_next;
    end
  end

  assign req_ready_o              = (state_reg == ST_IDLE);
  assign rsp_valid_o              = valid_reg;
  assign rsp_code_o               = code_reg;
  assign rsp_protected_o          = prot_reg;
  assign flash_addr_o             = addr_reg;
  assign flash_addr_low_o         = 1'b0;
  assign flash_byte_n_o           = ~byte_reg;
  assign elevated_query_voltage_o = hv_reg;
  assign flash_ce_n_o             = ~rd_reg;
  assign flash_oe_n_o             = ~rd_reg;
  assign flash_we_n_o             = 1'b1;

  property p_hv_during_read;
    @(posedge sys_clk_i) disable iff (!rst_n)
      !flash_oe_n_o |-> elevated_query_voltage_o;
  endproperty
  a_hv_during_read: assert property (p_hv_during_read)
    else $error("read without elevated voltage");

  property p_read_pins;
    @(posedge sys_clk_i) disable iff (!rst_n)
      !flash_oe_n_o |-> (!flash_ce_n_o && flash_we_n_o);
  endproperty
  a_read_pins: assert property (p_read_pins)
    else $error("bad read pin levels");

  property p_setup_first;
    @(posedge sys_clk_i) disable iff (!rst_n)
      $rose(elevated_query_voltage_o) |-> flash_oe_n_o [*5];
  endproperty
  a_setup_first: assert property (p_setup_first)
    else $error("read before setup time");

  property p_a6_low;
    @(posedge sys_clk_i) disable iff (!rst_n)
      elevated_query_voltage_o |-> !flash_addr_o[ADDR_BIT_A6];
  endproperty
  a_a6_low: assert property (p_a6_low)
    else $error("A6 not low in query");

  property p_addr_stable;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (!flash_oe_n_o && $past(!flash_oe_n_o)) |-> $stable(flash_addr_o);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address moved during read");

  property p_prot_code;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (rsp_valid_o && rsp_protected_o) |-> rsp_code_o == PROT_YES;
  endproperty
  a_prot_code: assert property (p_prot_code)
    else $error("protect flag without 01h");

  property p_release;
    @(posedge sys_clk_i) disable iff (!rst_n)
      rsp_valid_o |=> !elevated_query_voltage_o;
  endproperty
  a_release: assert property (p_release)
    else $error("voltage kept after answer");

  property p_answer_bound;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (req_valid_i && req_ready_o) |-> ##[25:30] rsp_valid_o;
  endproperty
  a_answer_bound: assert property (p_answer_bound)
    else $error("answer not in time");

endmodule // flash_id_host
`default_nettype wire

// ### dv/flash_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model
  import flash_id_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h1d, // Arbitrary value
  parameter logic [7:0] DEV_CODE   = 8'h3c, // Arbitrary value
  parameter logic [7:0] CONT_CODE  = 8'h6e, // Arbitrary value
  parameter logic [5:0] PROT_GRP   = 6'h3f
) (
  // Pins from the host
  input  wire logic [20:0] addr_i,
  input  wire logic        addr_low_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        byte_n_i,
  input  wire logic        hv_i,
  // Data pins
  output logic      [15:0] data_o
);
  logic [7:0]  id_byte;
  logic [15:0] word;

  // Bank bits on top do not change the maker, device or continuation codes
  always_comb begin
    case (addr_i[1:0])
      SEL_MAKER:  id_byte = MAKER_CODE;
      SEL_DEVICE: id_byte = DEV_CODE;
      SEL_CONT:   id_byte = CONT_CODE;
      default:    id_byte = (addr_i[20:15] == PROT_GRP) ? PROT_YES : PROT_NO;
    endcase
    if (hv_i && !addr_i[6]) begin
      word = {~id_byte, id_byte};
    end else begin
      word = {addr_i[14:0], addr_low_i & ~byte_n_i} ^ 16'h5a5a;
    end
  end

  // Lines churn until the access time has passed
  initial data_o = 16'h0000;
  always @(word, ce_n_i, oe_n_i, we_n_i) begin
    data_o <= ~data_o;
    if (!ce_n_i && !oe_n_i && we_n_i) begin
      data_o <= #T_ACCESS_NS word;
    end
  end
endmodule // flash_dev_model
`default_nettype wire

// ### dv/flash_id_host_bench.sv
`timescale 1ns/1ns
`default_nettype none
module flash_id_host_bench;
  import flash_id_pkg::*;
  localparam logic [7:0] MAKER_C = 8'h1d; // Arbitrary value
  localparam logic [7:0] DEV_C   = 8'h3c; // Arbitrary value
  localparam logic [7:0] CONT_C  = 8'h6e; // Arbitrary value
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        req_valid_i = 1'b0;
  logic [1:0]  req_sel_i = 2'h0;
  logic [8:0]  req_sector_i = 9'h000;
  logic [2:0]  req_bank_i = 3'h0;
  logic        req_byte_mode_i = 1'b0;
  logic        req_ready_o, rsp_valid_o, rsp_protected_o;
  logic [7:0]  rsp_code_o;
  logic [20:0] addr;
  logic        addr_low, ce_n, oe_n, we_n, byte_n, hv;
  logic [15:0] data;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #2 sys_clk_i = ~sys_clk_i;

  flash_id_host #(.BANK_BITS(3)) uut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_sel_i(req_sel_i),
    .req_sector_i(req_sector_i), .req_bank_i(req_bank_i),
    .req_byte_mode_i(req_byte_mode_i), .rsp_valid_o(rsp_valid_o),
    .rsp_code_o(rsp_code_o), .rsp_protected_o(rsp_protected_o),
    .flash_addr_o(addr), .flash_addr_low_o(addr_low), .flash_ce_n_o(ce_n),
    .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_byte_n_o(byte_n),
    .elevated_query_voltage_o(hv), .flash_data_i(data));

  flash_dev_model #(.MAKER_CODE(MAKER_C), .DEV_CODE(DEV_C),
    .CONT_CODE(CONT_C)) dev (
    .addr_i(addr), .addr_low_i(addr_low), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .byte_n_i(byte_n), .hv_i(hv), .data_o(data));

  task automatic test_done();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [20:0] exp,
                     input logic [20:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic query(input logic [1:0] sel, input logic [8:0] sect,
                       input logic [2:0] bank, input logic bmode,
                       input logic [7:0] exp);
    int n;
    @(posedge sys_clk_i);
    req_valid_i     <= 1'b1;
    req_sel_i       <= sel;
    req_sector_i    <= sect;
    req_bank_i      <= bank;
    req_byte_mode_i <= bmode;
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    for (n = 1; n <= 30; n++) begin
      @(posedge sys_clk_i);
      #1;
      if (n == 10) begin
        chk("ready", 1'b0, req_ready_o);
        chk("ce_n", 1'b0, ce_n);
        chk("oe_n", 1'b0, oe_n);
        chk("we_n", 1'b1, we_n);
        chk("hv", 1'b1, hv);
        chk("a6", 1'b0, addr[6]);
        chk("a1a0", sel, addr[1:0]);
        if (!sel[0]) chk("a3a2", 2'h0, addr[3:2]);
        chk("byte_n", !bmode, byte_n);
        chk("a_low", 1'b0, addr_low);
        if (sel == SEL_PROTECT)
          chk("sector", {sect[8:3], 3'h0}, addr[20:12]);
        else if (sel != SEL_CONT)
          chk("bank", bank, addr[20:18]);
      end
      if (rsp_valid_o === 1'b1) break;
    end
    // Setup count, read count up to access plus sync margin, done, pulse
    chk("latency", 21'(SETUP_CYC + ACCESS_CYC + 5), n[20:0]);
    chk("code", exp, rsp_code_o);
    if (sel == SEL_PROTECT)
      chk("prot", exp == PROT_YES, rsp_protected_o);
    @(posedge sys_clk_i);
    #1;
    chk("pulse", 1'b0, rsp_valid_o);
    chk("hv_off", 1'b0, hv);
  endtask

  task automatic t_ids_word();
    query(SEL_MAKER, 9'h000, 3'h5, 1'b0, MAKER_C);
    query(SEL_DEVICE, 9'h000, 3'h7, 1'b0, DEV_C);
    query(SEL_CONT, 9'h1ff, 3'h2, 1'b0, CONT_C);
  endtask

  task automatic t_ids_byte();
    query(SEL_DEVICE, 9'h000, 3'h1, 1'b1, DEV_C);
    query(SEL_CONT, 9'h000, 3'h4, 1'b1, CONT_C);
  endtask

  task automatic t_protect();
    query(SEL_PROTECT, 9'h1ff, 3'h0, 1'b0, PROT_YES);
    query(SEL_PROTECT, 9'h1f8, 3'h0, 1'b1, PROT_YES);
    query(SEL_PROTECT, 9'h1f7, 3'h0, 1'b0, PROT_NO);
    query(SEL_PROTECT, 9'h0a8, 3'h0, 1'b1, PROT_NO);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    t_ids_word();
    t_ids_byte();
    t_protect();
    test_done();
  end

  // Cut a hang short
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      test_done();
    end
  end
endmodule // flash_id_host_bench
`default_nettype wire
